// file: hdl/qnd_pkg.sv
package qnd_pkg;
    // queue geometry
    localparam int TAG_W = 5;
    localparam int NTAG = 32;

    // command block encodings
    localparam logic [7:0] OPC_NCQ_NONDATA = 8'h63;
    localparam logic [3:0] SUB_QUEUE_ABORT = 4'h0;
    localparam int SUB_LSB = 0;
    localparam int TYPE_LSB = 4;
    localparam int TAG_LSB = 3;

    // abort types
    localparam logic [3:0] TYPE_ALL = 4'h0;
    localparam logic [3:0] TYPE_STREAMING = 4'h1;
    localparam logic [3:0] TYPE_NONSTREAMING = 4'h2;
    localparam logic [3:0] TYPE_SELECTED = 4'h3;
    localparam logic [15:0] CAP_RESET = 16'h000F;

    // error and status flag positions
    localparam int ERR_ABORTED_BIT = 2;
    localparam int STS_ERR_BIT = 0;
    localparam int STS_SEEK_DONE_BIT = 4;
    localparam int STS_READY_BIT = 6;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // controller register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_ACT = 8'h0C;
    localparam logic [7:0] REG_CAP = 8'h10;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;
    localparam int CTRL_GO_BIT = 0;
    localparam int RESULT_BUSY_BIT = 16;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [31:0] CMD_RESET = 32'h0000_0063;
endpackage

// file: hdl/qnd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface qnd_link_if;
    // command block from the host
    logic cmd_valid;
    logic cmd_ready;
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    // completion from the device
    logic done;
    logic [7:0] command_error_flags;
    logic [7:0] command_status_flags;
    logic [qnd_pkg::NTAG-1:0] sdb_act;
    logic [15:0] abort_type_cap;

    modport device (
        input cmd_valid, command, feature, sector_count, sector_number,
        output cmd_ready, done, command_error_flags, command_status_flags, sdb_act,
        output abort_type_cap
    );
    modport host (
        output cmd_valid, command, feature, sector_count, sector_number,
        input cmd_ready, done, command_error_flags, command_status_flags, sdb_act,
        input abort_type_cap
    );
endinterface
`default_nettype wire

// file: hdl/qnd_device.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - opcode 63h dispatches to subcommand handling
// - feature low nibble 0h selects queue abort
// - feature high nibble gives abort type
// - host tag in count bits 7-3, unique
// - target tag in sector bits 7-3, type 3
// - host keeps target tag within queue depth
// - type 0h aborts all outstanding
// - type 1h aborts streaming only
// - type 2h aborts non-streaming only
// - type 3h aborts the matching tag
// - supported type succeeds even aborting nothing
// - completion sets ACT for self and aborted
// - reject when queuing is disabled
// - reject when target tag equals own tag
// - reject when target tag is invalid
// - reject unsupported abort type
module qnd_device #(
    parameter logic [15:0] CAP = qnd_pkg::CAP_RESET
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link to the host
    qnd_link_if.device link,
    // queue state from the protocol engine
    input wire logic queue_enabled_i,
    input wire logic [qnd_pkg::TAG_W-1:0] max_tag_i,
    input wire logic [qnd_pkg::NTAG-1:0] outstanding_i,
    input wire logic [qnd_pkg::NTAG-1:0] streaming_i,
    // abort order to the protocol engine
    output logic abort_valid_o,
    output logic [qnd_pkg::NTAG-1:0] abort_mask_o,
    output logic [15:0] reject_count_o
);
    import qnd_pkg::*;

    typedef enum logic [1:0] {
        QND_IDLE,
        QND_DECODE,
        QND_REPORT
    } qnd_state_t;

    qnd_state_t state;
    logic [7:0] cmd_opcode;
    logic [7:0] cmd_feature;
    logic [7:0] cmd_count;
    logic [7:0] cmd_sector;
    logic [3:0] subcommand;
    logic [3:0] abort_type;
    logic [TAG_W-1:0] own_tag;
    logic [TAG_W-1:0] target_tag;
    logic type_ok;
    logic target_bad;
    logic next_reject;
    logic [NTAG-1:0] next_select;
    logic [NTAG-1:0] own_bit;
    logic reject;
    logic [7:0] err_flags;
    logic [7:0] sts_flags;
    logic [NTAG-1:0] act;

    // one command at a time; the engine is idle only between commands
    assign link.cmd_ready = (state == QND_IDLE);
    assign link.done = (state == QND_REPORT);
    assign link.command_error_flags = err_flags;
    assign link.command_status_flags = sts_flags;
    assign link.sdb_act = act;
    assign link.abort_type_cap = CAP;

    // field extraction
    assign subcommand = cmd_feature[SUB_LSB +: 4];
    assign abort_type = cmd_feature[TYPE_LSB +: 4];
    assign own_tag = cmd_count[TAG_LSB +: TAG_W];
    assign target_tag = cmd_sector[TAG_LSB +: TAG_W];
    assign own_bit = NTAG'(1) << own_tag;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= QND_IDLE;
        end else begin
            case (state)
                QND_IDLE: begin
                    if (link.cmd_valid) begin
                        state <= QND_DECODE;
                    end
                end
                QND_DECODE: begin
                    state <= QND_REPORT;
                end
                QND_REPORT: begin
                    state <= QND_IDLE;
                end
                default: begin
                    state <= QND_IDLE;
                end
            endcase
        end
    end

    // command block captured at the handshake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_opcode <= 8'h00;
            cmd_feature <= 8'h00;
            cmd_count <= 8'h00;
            cmd_sector <= 8'h00;
        end else if (state == QND_IDLE && link.cmd_valid) begin
            cmd_opcode <= link.command;
            cmd_feature <= link.feature;
            cmd_count <= link.sector_count;
            cmd_sector <= link.sector_number;
        end
    end

    // checks; target tag only matters for a selected abort
    always_comb begin
        type_ok = CAP[abort_type];
        target_bad = 1'b0;
        if (abort_type == TYPE_SELECTED) begin
            target_bad = (target_tag == own_tag)
                || (target_tag > max_tag_i);
        end
        next_reject = (cmd_opcode != OPC_NCQ_NONDATA)
            || (subcommand != SUB_QUEUE_ABORT)
            || !queue_enabled_i
            || !type_ok
            || target_bad;
    end

    // selection of victims; the abort itself never aborts its own tag
    always_comb begin
        case (abort_type)
            TYPE_ALL: begin
                next_select = outstanding_i;
            end
            TYPE_STREAMING: begin
                next_select = outstanding_i & streaming_i;
            end
            TYPE_NONSTREAMING: begin
                next_select = outstanding_i & ~streaming_i;
            end
            TYPE_SELECTED: begin
                next_select = outstanding_i & (NTAG'(1) << target_tag);
            end
            default: begin
                next_select = '0;
            end
        endcase
        next_select = next_select & ~own_bit;
    end

    // verdict, taken against the queue as it stands in the decode cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reject <= 1'b0;
        end else if (state == QND_DECODE) begin
            reject <= next_reject;
        end
    end

    // completion flags and set device bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_flags <= FLAGS_RESET;
            sts_flags <= FLAGS_RESET;
            act <= '0;
        end else if (state == QND_DECODE) begin
            err_flags <= FLAGS_RESET;
            sts_flags <= FLAGS_RESET;
            sts_flags[STS_READY_BIT] <= 1'b1;
            sts_flags[STS_SEEK_DONE_BIT] <= 1'b1;
            if (next_reject) begin
                err_flags[ERR_ABORTED_BIT] <= 1'b1;
                sts_flags[STS_ERR_BIT] <= 1'b1;
                act <= '0;
            end else begin
                // success even with nothing aborted
                act <= own_bit | next_select;
            end
        end
    end

    // abort order to the engine, pulsed with the completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_valid_o <= 1'b0;
            abort_mask_o <= '0;
        end else begin
            abort_valid_o <= (state == QND_DECODE) && !next_reject;
            abort_mask_o <= (state == QND_DECODE && !next_reject) ? next_select : '0;
        end
    end

    // saturating so a diagnostics read never wraps to a small number
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reject_count_o <= 16'h0000;
        end else if (state == QND_REPORT && reject && reject_count_o != 16'hFFFF) begin
            reject_count_o <= reject_count_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// file: hdl/qnd_host.sv
`timescale 1ns/1ns
`default_nettype none
module qnd_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt
    output logic irq_o,
    // link to the device
    qnd_link_if.host link
);
    import qnd_pkg::*;

    logic [31:0] cmd_word;
    logic pending;
    logic waiting;
    logic [7:0] res_err;
    logic [7:0] res_sts;
    logic [NTAG-1:0] res_act;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic wr;
    logic go;
    logic busy;

    // write lands on the edge where the master sees ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign busy = pending || waiting;
    assign go = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_GO_BIT] && !busy;

    // host fills opcode, feature, own tag and target tag fields
    assign link.cmd_valid = pending;
    assign link.command = cmd_word[7:0];
    assign link.feature = cmd_word[15:8];
    assign link.sector_count = cmd_word[23:16];
    assign link.sector_number = cmd_word[31:24];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_adr_i == REG_CMD) begin
                wb_dat_o <= cmd_word;
            end else if (wb_adr_i == REG_RESULT) begin
                wb_dat_o <= {15'h0000, busy, res_sts, res_err};
            end else if (wb_adr_i == REG_ACT) begin
                wb_dat_o <= res_act;
            end else if (wb_adr_i == REG_CAP) begin
                wb_dat_o <= {16'h0000, link.abort_type_cap};
            end else if (wb_adr_i == REG_IRQ_STATUS) begin
                wb_dat_o <= {30'h0000_0000, irq_status};
            end else if (wb_adr_i == REG_IRQ_MASK) begin
                wb_dat_o <= {30'h0000_0000, irq_mask};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // command word; frozen while a command is in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_word <= CMD_RESET;
        end else if (wr && wb_adr_i == REG_CMD && !busy) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    cmd_word[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= 1'b0;
            waiting <= 1'b0;
        end else begin
            if (go) begin
                pending <= 1'b1;
            end else if (pending && link.cmd_ready) begin
                pending <= 1'b0;
                waiting <= 1'b1;
            end
            if (link.done) begin
                waiting <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_err <= FLAGS_RESET;
            res_sts <= FLAGS_RESET;
            res_act <= '0;
        end else if (link.done) begin
            res_err <= link.command_error_flags;
            res_sts <= link.command_status_flags;
            res_act <= link.sdb_act;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_DONE_BIT] = link.done && !link.command_status_flags[STS_ERR_BIT];
        irq_set[IRQ_REJECT_BIT] = link.done && link.command_status_flags[STS_ERR_BIT];
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            if (wr && wb_adr_i == REG_IRQ_STATUS && wb_sel_i[0]) begin
                irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
            if (wr && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// file: test/qnd_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module qnd_asserts
    import qnd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link signals
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] command,
    input wire logic [7:0] feature,
    input wire logic [7:0] sector_count,
    input wire logic [7:0] sector_number,
    input wire logic done,
    input wire logic [7:0] command_error_flags,
    input wire logic [7:0] command_status_flags,
    input wire logic [qnd_pkg::NTAG-1:0] sdb_act,
    input wire logic [15:0] abort_type_cap
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic take;
    logic aborted;
    logic [TAG_W-1:0] own_q;
    assign take = cmd_valid && cmd_ready;
    assign aborted = command_error_flags[ERR_ABORTED_BIT];

    // own tag kept so the completion check does not lean on the host holding it
    always_ff @(posedge clk_i) begin
        if (take) begin
            own_q <= sector_count[7:3];
        end
    end

    chk_take_to_done: assert property (take |=> !cmd_ready && !done ##1 done && !cmd_ready ##1 cmd_ready)
        else $error("completion timing wrong");
    chk_done_one_cycle: assert property (done |=> !done)
        else $error("done longer than one cycle");
    chk_opcode_reject: assert property (take && command != OPC_NCQ_NONDATA |-> ##2 done && aborted)
        else $error("foreign opcode not rejected");
    chk_subcode_reject: assert property (take && feature[3:0] != SUB_QUEUE_ABORT |-> ##2 aborted)
        else $error("subcommand not rejected");
    chk_type_cap: assert property (take && !abort_type_cap[feature[7:4]] |-> ##2 aborted)
        else $error("unsupported type not rejected");
    chk_self_target: assert property (take && feature[7:4] == TYPE_SELECTED
        && sector_number[7:3] == sector_count[7:3] |-> ##2 aborted)
        else $error("own tag target not rejected");
    chk_reject_flags: assert property (done && aborted |-> command_status_flags == 8'h51 && sdb_act == '0)
        else $error("reject flags wrong");
    chk_success_flags: assert property (done && !aborted |-> command_status_flags == 8'h50
        && command_error_flags == 8'h00 && sdb_act[own_q])
        else $error("success flags wrong");
    chk_result_hold: assert property (!done |-> $stable(sdb_act) && $stable(command_error_flags))
        else $error("result changed without completion");
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import qnd_pkg::*;
    typedef struct packed {
        logic [31:0] cmd;
        logic qen;
        logic rej;
        logic [31:0] mask;
    } qnd_row_t;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic queue_enabled_i = 1'h1;
    logic abort_valid_o;
    logic [31:0] abort_mask_o;
    logic [15:0] reject_count_o;
    logic [31:0] last_mask = 32'h0;
    logic [31:0] rd;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rejects = 0;
    // own tag 3 in every row; outstanding F0F6, streaming 30A4, top tag 15
    qnd_row_t rows [0:12] = '{
        '{32'h0018_0063, 1'h1, 1'h0, 32'h0000_F0F6},
        '{32'h1818_0063, 1'h1, 1'h0, 32'h0000_F0F6},
        '{32'h0018_1063, 1'h1, 1'h0, 32'h0000_30A4},
        '{32'h0018_2063, 1'h1, 1'h0, 32'h0000_C052},
        '{32'h2818_3063, 1'h1, 1'h0, 32'h0000_0020},
        '{32'h4018_3063, 1'h1, 1'h0, 32'h0000_0000},
        '{32'h7818_3063, 1'h1, 1'h0, 32'h0000_8000},
        '{32'h0018_0063, 1'h0, 1'h1, 32'h0000_0000},
        '{32'h1818_3063, 1'h1, 1'h1, 32'h0000_0000},
        '{32'h8018_3063, 1'h1, 1'h1, 32'h0000_0000},
        '{32'h0018_4063, 1'h1, 1'h1, 32'h0000_0000},
        '{32'h0018_0163, 1'h1, 1'h1, 32'h0000_0000},
        '{32'h0018_0062, 1'h1, 1'h1, 32'h0000_0000}
    };

    qnd_link_if u_qnd_link_if ();
    qnd_device u_qnd_device (.clk_i(clk_i), .rst_i(rst_i), .link(u_qnd_link_if),
        .queue_enabled_i(queue_enabled_i), .max_tag_i(5'h0F),
        .outstanding_i(32'h0000_F0F6), .streaming_i(32'h0000_30A4),
        .abort_valid_o(abort_valid_o), .abort_mask_o(abort_mask_o),
        .reject_count_o(reject_count_o));
    qnd_host u_qnd_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link(u_qnd_link_if));
    qnd_asserts u_qnd_asserts (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_valid(u_qnd_link_if.cmd_valid), .cmd_ready(u_qnd_link_if.cmd_ready),
        .command(u_qnd_link_if.command), .feature(u_qnd_link_if.feature),
        .sector_count(u_qnd_link_if.sector_count), .sector_number(u_qnd_link_if.sector_number),
        .done(u_qnd_link_if.done), .command_error_flags(u_qnd_link_if.command_error_flags),
        .command_status_flags(u_qnd_link_if.command_status_flags),
        .sdb_act(u_qnd_link_if.sdb_act), .abort_type_cap(u_qnd_link_if.abort_type_cap));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // mask seen at completion; zero when no abort order went out
    always @(posedge clk_i) begin
        if (u_qnd_link_if.done === 1'h1) begin
            last_mask <= (abort_valid_o === 1'h1) ? abort_mask_o : 32'h0;
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask

    // waits have no limit of their own; the cycle ceiling ends a hang
    task automatic run_cmd(input logic [31:0] cmd);
        wb(1'h1, REG_CMD, cmd);
        wb(1'h1, REG_IRQ_STATUS, 32'h3);
        wb(1'h1, REG_CTRL, 32'h1);
        while (u_qnd_link_if.done !== 1'h1) begin
            @(posedge clk_i);
        end
        rd = 32'h0001_0000;
        while (rd[RESULT_BUSY_BIT] !== 1'h0) begin
            wb(1'h0, REG_RESULT, 32'h0);
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, REG_CMD, 32'h0);
        check("cmd reset", CMD_RESET, rd);
        wb(1'h0, REG_RESULT, 32'h0);
        check("result reset", 32'h0, rd);
        wb(1'h1, REG_CAP, 32'h0);
        wb(1'h0, REG_CAP, 32'h0);
        check("cap list", {16'h0, CAP_RESET}, rd);
        wb(1'h1, 8'h40, 32'hFFFF_FFFF);
        wb(1'h0, 8'h40, 32'h0);
        check("unmapped", 32'h0, rd);
        for (int i = 0; i < 13; i++) begin
            queue_enabled_i <= rows[i].qen;
            run_cmd(rows[i].cmd);
            check("result", rows[i].rej ? 32'h0000_5104 : 32'h0000_5000, rd);
            wb(1'h0, REG_ACT, 32'h0);
            check("act", rows[i].rej ? 32'h0 : (rows[i].mask | 32'h8), rd);
            check("abort mask", rows[i].mask, last_mask);
            wb(1'h0, REG_IRQ_STATUS, 32'h0);
            check("irq status", rows[i].rej ? 32'h2 : 32'h1, rd);
            if (rows[i].rej) begin
                rejects++;
            end
        end
        check("reject count", rejects, {16'h0, reject_count_o});
        // reject pending but only done is unmasked
        wb(1'h1, REG_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq masked", 32'h0, {31'h0, irq_o});
        queue_enabled_i <= 1'h1;
        run_cmd(rows[0].cmd);
        repeat (2) @(posedge clk_i);
        check("irq raised", 32'h1, {31'h0, irq_o});
        wb(1'h1, REG_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq cleared", 32'h0, {31'h0, irq_o});
        // command writes refused while a command is in flight
        wb(1'h1, REG_CMD, rows[4].cmd);
        wb(1'h1, REG_CTRL, 32'h1);
        wb(1'h1, REG_CMD, rows[12].cmd);
        wb(1'h0, REG_CMD, 32'h0);
        check("cmd frozen", rows[4].cmd, rd);
        // reset in mid-run, with a command just launched
        wb(1'h1, REG_CTRL, 32'h1);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, REG_CMD, 32'h0);
        check("cmd after reset", CMD_RESET, rd);
        wb(1'h0, REG_RESULT, 32'h0);
        check("result after reset", 32'h0, rd);
        wb(1'h0, REG_ACT, 32'h0);
        check("act after reset", 32'h0, rd);
        check("count after reset", 32'h0, {16'h0, reject_count_o});
        check("irq after reset", 32'h0, {31'h0, irq_o});
        report_and_stop();
    end
endmodule
`default_nettype wire
